// file: rtl/eep_pkg.sv
// Shared constants and types of the serial memory slave
package eep_pkg;
    // ------------------------------------------------------------
    // Array and byte layout
    // ------------------------------------------------------------
    localparam int MEM_AW = 14;
    localparam int MEM_DW = 8;
    localparam int MEM_WORDS = 16384;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int STRAP_W = 3;
    localparam int PAGE_BITS = 6;
    localparam int ADDR_HI_W = MEM_AW - 8;
    // Device-type code: arbitrary value
    localparam logic [3:0] DEV_TYPE_DEF = 4'h5;
    // Address byte fields
    localparam int RW_POS = 0;
    localparam int STRAP_LSB = 1;
    localparam int TYPE_LSB = 4;
    // Bit counter marks
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint WRITE_TIME_NS = 5000000;
    localparam longint CLK_PERIOD_PS = 4000;
    localparam int WRITE_CYCLES = int'((WRITE_TIME_NS * 64'd1000) / CLK_PERIOD_PS);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADRH,
        ST_ADRL,
        ST_WDATA,
        ST_RDATA
    } eep_state_t;

    typedef struct packed {
        logic wr;
        logic [MEM_AW-1:0] addr;
        logic [MEM_DW-1:0] data;
    } eep_req_t;
endpackage : eep_pkg

// file: rtl/eep_sync.sv
// Two-stage synchroniser for a group of levels
`timescale 1ns/1ps
module eep_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clock) begin
        meta_q <= d;
        q <= meta_q;
    end
endmodule : eep_sync

// file: rtl/eep_mem.sv
// Byte array with erase sweep after reset
`timescale 1ns/1ps
module eep_mem
    import eep_pkg::*;
#(
    parameter int AW = MEM_AW,
    parameter int DW = MEM_DW,
    parameter int FILL_WORDS = MEM_WORDS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic we,
    input wire logic re,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata,
    output logic ready
);
    logic [DW-1:0] mem [2**AW];
    logic fill_q;
    logic [AW-1:0] fill_cnt_q;

    // Sweep counter, all words erased before first use
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fill_q <= 1'b1;
            fill_cnt_q <= '0;
        end else if (fill_q) begin
            fill_cnt_q <= fill_cnt_q + 1'b1;
            if (fill_cnt_q == AW'(FILL_WORDS - 1)) begin
                fill_q <= 1'b0;
            end
        end
    end

    // Array write: erase value during sweep
    always_ff @(posedge clock) begin
        if (fill_q) begin
            mem[fill_cnt_q] <= DW'(ERASED_BYTE);
        end else if (we) begin
            mem[addr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (re && !fill_q) begin
            rdata <= mem[addr];
        end
    end

    assign ready = !fill_q;

    fill_span_a: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(fill_q) |-> $past(fill_cnt_q) == AW'(FILL_WORDS - 1))
        else $error("erase sweep ended early");
endmodule : eep_mem

// file: rtl/eep_top.sv
// Two-wire serial memory slave: pin logic, sequencing and array
//
// Behaviour
// - Three strap inputs set the slave address, eight choices per bus.
// - Respond only when sent address bits equal the strap value.
// - Open strap pins read as low through pad pull-downs.
// - Data pin sampled as input, driven only low via open drain.
// - Write-protect high inhibits writes to the array.
// - Write-protect low or open leaves writes allowed.
// - Every location reads all ones before its first write.
// - Start is data falling while the serial clock stays high.
// - Master opens with start; device does nothing before one.
// - Bus actions happen at serial clock rising or falling edges, and at start and stop conditions.
// - Stop ends a read quietly, or launches the pending write cycle.
// - Eight bits per transfer; device pulls data low on ninth clock.
// - Address byte: fixed type code, strap bits, read/write bit.
// - No acknowledge at all while an internal write cycle runs.
`timescale 1ns/1ps
module eep_top
    import eep_pkg::*;
#(
    parameter int INIT_WORDS = MEM_WORDS,
    parameter int WRITE_CYC = WRITE_CYCLES,
    parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic wp_i
);
    localparam int CW = $clog2(WRITE_CYC + 1);

    // ------------------------------------------------------------
    // Crossing signals
    // ------------------------------------------------------------
    logic link_rst_n;
    logic scl_s, sda_s, wp_l, busy_l, rsp_l;
    logic [STRAP_W-1:0] strap_l;
    logic req_s, wp_s;
    eep_req_t req_q;
    logic req_tgl_q, rsp_tgl_q, busy_q;
    logic [MEM_DW-1:0] mem_rdata;
    logic mem_ready;

    // Link-domain reset follows the system reset
    eep_sync #(.W(1)) u_lrst (
        .clock(link_clk),
        .d(rst_n),
        .q(link_rst_n)
    );

    // Pins and system status into the link domain
    eep_sync #(.W(8)) u_lsync (
        .clock(link_clk),
        .d({scl_i, sda_i, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
            wp_i, busy_q, rsp_tgl_q}),
        .q({scl_s, sda_s, strap_l, wp_l, busy_l, rsp_l})
    );

    // Request toggle and protect level into the system domain
    eep_sync #(.W(2)) u_ssync (
        .clock(clock),
        .d({req_tgl_q, wp_i}),
        .q({req_s, wp_s})
    );

    // ------------------------------------------------------------
    // Link domain: bus conditions
    // ------------------------------------------------------------
    logic scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, start, stop;

    // Previous sampled levels for edge detection
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    assign start = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop = scl_s && scl_p_q && !sda_p_q && sda_s;

    // ------------------------------------------------------------
    // Link domain: sequencer
    // ------------------------------------------------------------
    eep_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic sda_oe_q, rw_q, mack_q, have_q, rsp_seen_q;
    logic [MEM_AW-1:0] addr_q;
    logic [MEM_DW-1:0] wdata_q, rd_byte_q;
    logic byte_end, ack_end, dev_hit, ack_give, next_rd;

    assign byte_end = scl_fall && bit_cnt_q == LAST_BIT && !start && !stop;
    assign ack_end = scl_fall && bit_cnt_q == ACK_SLOT && !start && !stop;
    // Type code and live strap levels against the received byte
    assign dev_hit = shift_q[TYPE_LSB +: 4] == DEV_TYPE
        && shift_q[STRAP_LSB +: STRAP_W] == strap_l;
    assign next_rd = (state_q == ST_DEV && rw_q) || (state_q == ST_RDATA && mack_q);

    // Acknowledge decision per received byte
    always_comb begin
        unique case (state_q)
            ST_DEV: ack_give = dev_hit && !busy_l;
            ST_ADRH, ST_ADRL: ack_give = !busy_l;
            ST_WDATA: ack_give = !busy_l && !wp_l;
            ST_IDLE, ST_RDATA: ack_give = 1'b0;
            default: ack_give = 1'b0;
        endcase
    end

    // State and bit count
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= '0;
        end else if (start) begin
            state_q <= ST_DEV;
            // All ones: the clock fall closing the start wraps it to zero
            bit_cnt_q <= '1;
        end else if (stop) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= '0;
        end else if (scl_fall && state_q != ST_IDLE) begin
            bit_cnt_q <= (bit_cnt_q == ACK_SLOT) ? 4'h0 : bit_cnt_q + 4'h1;
            if (byte_end && state_q != ST_RDATA && !ack_give) begin
                state_q <= ST_IDLE;
            end else if (ack_end) begin
                unique case (state_q)
                    ST_DEV: state_q <= rw_q ? ST_RDATA : ST_ADRH;
                    ST_ADRH: state_q <= ST_ADRL;
                    ST_ADRL: state_q <= ST_WDATA;
                    ST_WDATA: state_q <= ST_WDATA;
                    ST_RDATA: state_q <= mack_q ? ST_RDATA : ST_IDLE;
                    ST_IDLE: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Shift register: receive on rise, transmit on fall
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            shift_q <= '0;
        end else if (scl_rise && bit_cnt_q < ACK_SLOT && state_q != ST_RDATA) begin
            shift_q <= {shift_q[6:0], sda_s};
        end else if (ack_end && next_rd) begin
            shift_q <= rd_byte_q;
        end else if (scl_fall && state_q == ST_RDATA && bit_cnt_q < LAST_BIT) begin
            shift_q <= {shift_q[6:0], 1'b0};
        end
    end

    // Open-drain pull-low enable
    always_ff @(posedge link_clk) begin
        if (!link_rst_n || start || stop) begin
            sda_oe_q <= 1'b0;
        end else if (byte_end) begin
            sda_oe_q <= ack_give;
        end else if (ack_end) begin
            sda_oe_q <= next_rd && !rd_byte_q[7];
        end else if (scl_fall && state_q == ST_RDATA && bit_cnt_q < LAST_BIT) begin
            sda_oe_q <= !shift_q[6];
        end
    end

    // Direction bit and master acknowledge on read bytes
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            rw_q <= 1'b0;
            mack_q <= 1'b0;
        end else begin
            if (byte_end && state_q == ST_DEV) begin
                rw_q <= shift_q[RW_POS];
            end
            if (scl_rise && bit_cnt_q == ACK_SLOT && state_q == ST_RDATA) begin
                mack_q <= !sda_s;
            end
        end
    end

    // Address pointer and held write byte
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            addr_q <= '0;
            wdata_q <= '0;
            have_q <= 1'b0;
        end else if (start) begin
            have_q <= 1'b0;
        end else if (stop) begin
            have_q <= 1'b0;
            if (state_q == ST_WDATA && have_q) begin
                addr_q[PAGE_BITS-1:0] <= addr_q[PAGE_BITS-1:0] + 1'b1;
            end
        end else if (byte_end && ack_give) begin
            unique case (state_q)
                ST_ADRH: addr_q[MEM_AW-1:8] <= shift_q[ADDR_HI_W-1:0];
                ST_ADRL: addr_q[7:0] <= shift_q;
                ST_WDATA: begin
                    wdata_q <= shift_q;
                    have_q <= 1'b1;
                end
                ST_IDLE, ST_DEV, ST_RDATA: ;
            endcase
        end else if (byte_end && state_q == ST_RDATA) begin
            addr_q <= addr_q + 1'b1;
        end
    end

    // Requests to the array: read prefetch, write at stop
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            req_q <= '0;
            req_tgl_q <= 1'b0;
        end else if (stop && state_q == ST_WDATA && have_q) begin
            req_q <= '{wr: 1'b1, addr: addr_q, data: wdata_q};
            req_tgl_q <= !req_tgl_q;
        end else if (byte_end && state_q == ST_DEV && ack_give && shift_q[RW_POS]) begin
            req_q <= '{wr: 1'b0, addr: addr_q, data: 8'h00};
            req_tgl_q <= !req_tgl_q;
        end else if (byte_end && state_q == ST_RDATA) begin
            req_q <= '{wr: 1'b0, addr: addr_q + 1'b1, data: 8'h00};
            req_tgl_q <= !req_tgl_q;
        end
    end

    // Read answer captured when its toggle arrives
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            rsp_seen_q <= 1'b0;
            rd_byte_q <= ERASED_BYTE;
        end else begin
            rsp_seen_q <= rsp_l;
            if (rsp_l != rsp_seen_q) begin
                rd_byte_q <= mem_rdata;
            end
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;

    // ------------------------------------------------------------
    // System domain: array access and write cycle
    // ------------------------------------------------------------
    logic req_seen_q, new_req, mem_we, mem_re, rd_pend_q;
    logic [CW-1:0] wr_cnt_q;

    assign new_req = req_s != req_seen_q;
    assign mem_we = new_req && req_q.wr && !wp_s && mem_ready;
    assign mem_re = new_req && !req_q.wr;

    eep_mem #(.AW(MEM_AW), .DW(MEM_DW), .FILL_WORDS(INIT_WORDS)) u_mem (
        .clock(clock),
        .rst_n(rst_n),
        .we(mem_we),
        .re(mem_re),
        .addr(req_q.addr),
        .wdata(req_q.data),
        .rdata(mem_rdata),
        .ready(mem_ready)
    );

    // Write timer and busy level toward the link
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_cnt_q <= '0;
            busy_q <= 1'b1;
        end else begin
            if (mem_we) begin
                wr_cnt_q <= CW'(WRITE_CYC);
            end else if (wr_cnt_q != '0) begin
                wr_cnt_q <= wr_cnt_q - 1'b1;
            end
            busy_q <= !mem_ready || mem_we || wr_cnt_q > CW'(1);
        end
    end

    // Request edge and read answer toggle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            req_seen_q <= 1'b0;
            rd_pend_q <= 1'b0;
            rsp_tgl_q <= 1'b0;
        end else begin
            req_seen_q <= req_s;
            rd_pend_q <= mem_re;
            if (rd_pend_q) begin
                rsp_tgl_q <= !rsp_tgl_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence byte_done_s;
        byte_end;
    endsequence

    sequence dev_byte_s;
        state_q == ST_DEV ##0 byte_done_s;
    endsequence

    start_abort_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        start |=> state_q == ST_DEV && bit_cnt_q == 4'hf && !sda_oe_q)
        else $error("start did not restart address reception");

    idle_hold_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        state_q == ST_IDLE && !start |=> state_q == ST_IDLE && !sda_oe_q)
        else $error("device left idle without a start");

    oe_edge_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        $rose(sda_oe_q) |-> $past(scl_fall))
        else $error("data pulled low away from a clock fall");

    addr_ack_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        dev_byte_s ##0 (dev_hit && !busy_l) |=> sda_oe_q ##1 sda_oe_q)
        else $error("matching address not acknowledged");

    addr_miss_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        dev_byte_s ##0 !dev_hit |=> state_q == ST_IDLE && !sda_oe_q)
        else $error("foreign address not ignored");

    busy_nack_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        byte_done_s ##0 busy_l |=> !sda_oe_q)
        else $error("acknowledge given during write cycle");

    wp_nack_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        state_q == ST_WDATA ##0 byte_done_s ##0 wp_l |=> !sda_oe_q && state_q == ST_IDLE)
        else $error("protected data byte acknowledged");

    stop_write_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        stop && state_q == ST_WDATA && have_q |=> $changed(req_tgl_q) && req_q.wr)
        else $error("stop did not post the write");

    wp_block_a: assert property (@(posedge clock) disable iff (!rst_n)
        new_req && req_q.wr && wp_s |=> wr_cnt_q == $past(wr_cnt_q) - CW'(1)
            || wr_cnt_q == '0)
        else $error("write cycle started under protection");

    write_busy_a: assert property (@(posedge clock) disable iff (!rst_n)
        mem_we |=> busy_q ##1 busy_q ##1 busy_q)
        else $error("busy not raised for write cycle");

    read_answer_a: assert property (@(posedge clock) disable iff (!rst_n)
        mem_re |-> ##2 rsp_tgl_q != $past(rsp_tgl_q))
        else $error("read answer toggle missing");
endmodule : eep_top

// file: bench/eep_master.sv
// Behavioural two-wire bus master that drives the serial pins
`timescale 1ns/1ps
module eep_master #(
    parameter int QTR = 64
) (
    input wire logic clock,
    input wire logic sda_bus,
    output logic scl,
    output logic sda_m
);
    // ------------------------------------------------------------
    // Idle bus: both lines released high
    // ------------------------------------------------------------
    initial begin
        scl = 1'h1;
        sda_m = 1'h1;
    end

    // ------------------------------------------------------------
    // Bus phases, all changes just after a falling edge
    // ------------------------------------------------------------
    // Quarter of a serial clock period
    task automatic qtr();
        repeat (QTR) @(negedge clock);
    endtask : qtr

    // Start from idle, or repeated start from a low clock
    task automatic start();
        sda_m = 1'h1;
        qtr();
        scl = 1'h1;
        qtr();
        sda_m = 1'h0;
        qtr();
        scl = 1'h0;
        qtr();
    endtask : start

    // Stop, then bus free time
    task automatic stop();
        sda_m = 1'h0;
        qtr();
        scl = 1'h1;
        qtr();
        sda_m = 1'h1;
        qtr();
        qtr();
    endtask : stop

    // Lower the clock with no start, as a faulty master would
    task automatic clock_low();
        scl = 1'h0;
        qtr();
    endtask : clock_low

    // One bit: data set while clock low, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda_m = b;
        qtr();
        scl = 1'h1;
        qtr();
        r = sda_bus;
        qtr();
        scl = 1'h0;
        qtr();
    endtask : bit_io

    // Byte out MSB first, then release for the slave acknowledge
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'h1, r);
        ack = ~r;
    endtask : byte_out

    // Byte in MSB first, then master acknowledge or not
    task automatic byte_in(input logic ack_m, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, r);
            d[i] = r;
        end
        bit_io(~ack_m, r);
    endtask : byte_in
endmodule : eep_master

// file: bench/testbench.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
module testbench
    import eep_pkg::*;
;
    localparam int INIT_N = 16;
    localparam int WCYC = 4000;
    localparam logic [2:0] STRAPS = 3'h5;

    logic clock;
    logic link_clk;
    logic rst_n;
    logic scl;
    logic sda_m;
    logic sda_bus;
    logic sda_o;
    logic sda_oe;
    logic wp_i;
    logic [2:0] straps;
    int failures;
    int compares;

    // ------------------------------------------------------------
    // Clocks, wired data line, instances
    // ------------------------------------------------------------
    initial begin
        clock = 1'h0;
        forever #2 clock = ~clock;
    end

    // Link clock, 30 ns, phase unrelated to the system clock
    initial begin
        link_clk = 1'h0;
        #7.3;
        forever #15 link_clk = ~link_clk;
    end

    // Pull-up wired bus: low when either party pulls it
    assign sda_bus = (sda_oe ? sda_o : 1'h1) & sda_m;

    eep_top #(
        .INIT_WORDS(INIT_N),
        .WRITE_CYC(WCYC)
    ) eep_top_inst (
        .clock(clock),
        .rst_n(rst_n),
        .link_clk(link_clk),
        .scl_i(scl),
        .sda_i(sda_bus),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .addr_strap_bit0(straps[0]),
        .addr_strap_bit1(straps[1]),
        .addr_strap_bit2(straps[2]),
        .wp_i(wp_i)
    );

    eep_master eep_master_inst (
        .clock(clock),
        .sda_bus(sda_bus),
        .scl(scl),
        .sda_m(sda_m)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Send one byte and judge the acknowledge and the drive level
    task automatic send(input logic [7:0] d, input logic exp, input string what);
        logic a;
        eep_master_inst.byte_out(d, a);
        check(what, {7'h00, a}, {7'h00, exp});
        check("sda_o", {7'h00, sda_o}, 8'h00);
    endtask : send

    task automatic wrap_up();
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Protected write to 4 refused; protect raised before stop blocks write to 5
    task automatic t_protected();
        wp_i = 1'h1;
        eep_master_inst.start();
        send({DEV_TYPE_DEF, STRAPS, 1'h0}, 1'h1, "dev ack");
        send(8'h00, 1'h1, "hi ack");
        send(8'h04, 1'h1, "lo ack");
        send(8'h00, 1'h0, "wp nack");
        eep_master_inst.stop();
        wp_i = 1'h0;
        eep_master_inst.start();
        send({DEV_TYPE_DEF, STRAPS, 1'h0}, 1'h1, "dev ack");
        send(8'h00, 1'h1, "hi ack");
        send(8'h05, 1'h1, "lo ack");
        send(8'h33, 1'h1, "open ack");
        wp_i = 1'h1;
        eep_master_inst.stop();
        wp_i = 1'h0;
    endtask : t_protected

    // Straps moved to ground while idle: new address answers, old one does not
    task automatic t_straps();
        straps = 3'h0;
        eep_master_inst.start();
        send({DEV_TYPE_DEF, 3'h0, 1'h0}, 1'h1, "ground ack");
        eep_master_inst.stop();
        eep_master_inst.start();
        send({DEV_TYPE_DEF, STRAPS, 1'h0}, 1'h0, "old strap nack");
        eep_master_inst.stop();
        straps = STRAPS;
    endtask : t_straps

    // Wrong straps, wrong type, aborted byte, missing start
    task automatic t_refusals();
        logic r;
        eep_master_inst.start();
        send({DEV_TYPE_DEF, 3'h4, 1'h0}, 1'h0, "strap nack");
        eep_master_inst.stop();
        eep_master_inst.start();
        send({DEV_TYPE_DEF ^ 4'h1, STRAPS, 1'h0}, 1'h0, "type nack");
        eep_master_inst.stop();
        eep_master_inst.start();
        for (int i = 0; i < 4; i++) begin
            eep_master_inst.bit_io(1'h0, r);
        end
        eep_master_inst.start();
        send({DEV_TYPE_DEF, STRAPS, 1'h0}, 1'h1, "restart ack");
        eep_master_inst.stop();
        eep_master_inst.clock_low();
        send({DEV_TYPE_DEF, STRAPS, 1'h0}, 1'h0, "no start nack");
        eep_master_inst.stop();
    endtask : t_refusals

    // Write 5a to location 3, then probe while the write runs
    task automatic t_write_busy();
        eep_master_inst.start();
        send({DEV_TYPE_DEF, STRAPS, 1'h0}, 1'h1, "dev ack");
        send(8'h00, 1'h1, "hi ack");
        send(8'h03, 1'h1, "lo ack");
        send(8'h5a, 1'h1, "data ack");
        eep_master_inst.stop();
        eep_master_inst.start();
        send({DEV_TYPE_DEF, STRAPS, 1'h1}, 1'h0, "busy nack");
        eep_master_inst.stop();
        repeat (WCYC) @(negedge clock);
    endtask : t_write_busy

    // Random read of locations 3, 4 and 5
    task automatic t_read_back();
        logic [7:0] d;
        eep_master_inst.start();
        send({DEV_TYPE_DEF, STRAPS, 1'h0}, 1'h1, "dev ack");
        send(8'h00, 1'h1, "hi ack");
        send(8'h03, 1'h1, "lo ack");
        eep_master_inst.start();
        send({DEV_TYPE_DEF, STRAPS, 1'h1}, 1'h1, "read ack");
        eep_master_inst.byte_in(1'h1, d);
        check("byte 3", d, 8'h5a);
        eep_master_inst.byte_in(1'h1, d);
        check("byte 4", d, ERASED_BYTE);
        eep_master_inst.byte_in(1'h0, d);
        check("byte 5", d, ERASED_BYTE);
        eep_master_inst.stop();
    endtask : t_read_back

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    // Reset for 20 cycles, then the erase sweep
    initial begin
        failures = 0;
        compares = 0;
        rst_n = 1'h0;
        wp_i = 1'h0;
        straps = STRAPS;
        repeat (20) @(negedge clock);
        rst_n = 1'h1;
        repeat (INIT_N + 10) @(negedge clock);
        t_protected();
        t_straps();
        t_refusals();
        t_write_busy();
        t_read_back();
        wrap_up();
    end

    // Bounded run length
    initial begin
        repeat (95000) @(posedge clock);
        failures++;
        wrap_up();
    end
endmodule : testbench
